// ===== rtl/bsrm_regmap.v
// Banked serial register map: bank selection, bank 0 config, static area, memory access.
`timescale 1ns/1ns
`default_nettype none
`include "bsrm_map.vh"

// What this block does
// - The internal space is cut into 64-byte banks and only one bank is reachable at a time.
// - Serial addresses 0x00-0x3F go to the selected bank and 0x40-0x7F form a fixed section.
// - The fixed section stays reachable whatever value the bank register holds.
// - Bits 4:0 at serial address 0x40 select the bank, and the host writes it before a switch.
// - After startup the bank register is cleared to zero so the window shows configuration.
// - With bank 0 selected the window reaches the on-chip configuration registers.
// - Banks 1 to 31 reach 64-byte areas of the external memory at bank times 0x40.
// - Bank 0 opens with coarse/fine gain, extra gain, sine offset and cosine offset fields.
module bsrm_regmap #(
    parameter DATA_W = 8
) (
    input  wire                        clk,
    input  wire                        rst,
    input  wire                        accValid,
    input  wire                        accWrite,
    input  wire [`BSRM_ADDR_W-1:0]     accAddr,
    input  wire [DATA_W-1:0]           accWdata,
    output reg                         accBusy_q,
    output reg                         accDone_q,
    output reg  [DATA_W-1:0]           rdData_q,
    output reg                         eeReq_q,
    output reg                         eeWrite_q,
    output reg  [`BSRM_EE_ADDR_W-1:0]  eeAddr_q,
    output reg  [DATA_W-1:0]           eeWdata_q,
    input  wire                        eeAck,
    input  wire [DATA_W-1:0]           eeRdata,
    output reg  [`BSRM_BANK_W-1:0]     bankSelect_q,
    output reg  [1:0]                  masterCoarseGain_q,
    output reg  [5:0]                  masterFineGain_q,
    output reg  [6:0]                  masterGainExtra_q,
    output reg  [6:0]                  masterSineOffset_q,
    output reg  [6:0]                  masterCosineOffset_q
);

    // ****************************************************************
    // States
    // ****************************************************************
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_MEM  = 2'h1;

    localparam NUM_BYTES = `BSRM_BANK_BYTES;
    // The register is a byte on the bus but only the bank field is stored.
    localparam [7:0] BANK_RST_BYTE = `BSRM_BANK_SELECT_RST;

    reg  [1:0]                  state_q;
    reg  [1:0]                  state_d;
    reg  [DATA_W-1:0]           configMem [0:NUM_BYTES-1];
    reg  [DATA_W-1:0]           staticMem [0:NUM_BYTES-1];
    wire                        isStatic;
    wire                        isConfig;
    wire                        isEeprom;
    wire [`BSRM_EE_ADDR_W-1:0]  xlateAddr;
    wire [`BSRM_OFS_W-1:0]      ofs;
    wire                        take;
    wire                        bankHit;

    assign ofs     = accAddr[`BSRM_OFS_W-1:0];
    assign take    = accValid && !accBusy_q;
    assign bankHit = (accAddr == `BSRM_BANK_SELECT_ADDR);

    // ****************************************************************
    // Address translation
    // ****************************************************************
    bsrm_bank_xlate uXlate (
        .serAddr  (accAddr),
        .bank     (bankSelect_q),
        .isStatic (isStatic),
        .isConfig (isConfig),
        .isEeprom (isEeprom),
        .eeAddr   (xlateAddr)
    );

    function [DATA_W-1:0] bank_read;
        input [`BSRM_BANK_W-1:0] bank;
        begin
            bank_read = {{(DATA_W-`BSRM_BANK_W){1'b0}}, bank};
        end
    endfunction

    // ****************************************************************
    // Bank selection register
    // ****************************************************************
    always @(posedge clk) begin
        if (rst) begin
            bankSelect_q <= BANK_RST_BYTE[`BSRM_BANK_W-1:0];
        end else if (take && accWrite && isStatic && bankHit) begin
            // Only the 5-bit field is kept; upper bits read back as zero.
            bankSelect_q <= accWdata[`BSRM_BANK_MSB:`BSRM_BANK_LSB];
        end
    end

    // ****************************************************************
    // Bank 0 configuration storage and static section storage
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BYTES; gi = gi + 1) begin : gMem
            always @(posedge clk) begin
                if (rst) begin
                    configMem[gi] <= `BSRM_CONFIG_RST;
                end else if (take && accWrite && isConfig && ofs == gi) begin
                    configMem[gi] <= accWdata;
                end
            end
            always @(posedge clk) begin
                if (rst) begin
                    staticMem[gi] <= `BSRM_STATIC_RST;
                end else if (take && accWrite && isStatic && !bankHit
                             && ofs == gi) begin
                    staticMem[gi] <= accWdata;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Master track conditioning fields
    // ****************************************************************
    // Registered copies so the analog front end sees clean flop outputs.
    always @(posedge clk) begin
        if (rst) begin
            masterCoarseGain_q   <= 2'h0;
            masterFineGain_q     <= 6'h00;
            masterGainExtra_q    <= 7'h00;
            masterSineOffset_q   <= 7'h00;
            masterCosineOffset_q <= 7'h00;
        end else begin
            masterCoarseGain_q   <= configMem[`BSRM_MASTER_GAIN_RANGE_AND_FINE]
                                    [`BSRM_COARSE_MSB:`BSRM_COARSE_LSB];
            masterFineGain_q     <= configMem[`BSRM_MASTER_GAIN_RANGE_AND_FINE]
                                    [`BSRM_FINE_MSB:`BSRM_FINE_LSB];
            masterGainExtra_q    <= configMem[`BSRM_MASTER_GAIN_EXTRA]
                                    [`BSRM_FIELD7_MSB:0];
            masterSineOffset_q   <= configMem[`BSRM_MASTER_SINE_OFFSET]
                                    [`BSRM_FIELD7_MSB:0];
            masterCosineOffset_q <= configMem[`BSRM_MASTER_COSINE_OFFSET]
                                    [`BSRM_FIELD7_MSB:0];
        end
    end

    // ****************************************************************
    // Access sequencer
    // ****************************************************************
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take && isEeprom) begin
                    state_d = ST_MEM;
                end
            end
            ST_MEM: begin
                if (eeAck) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            state_q   <= ST_IDLE;
            accBusy_q <= 1'b0;
            accDone_q <= 1'b0;
            rdData_q  <= {DATA_W{1'b0}};
            eeReq_q   <= 1'b0;
            eeWrite_q <= 1'b0;
            eeAddr_q  <= {`BSRM_EE_ADDR_W{1'b0}};
            eeWdata_q <= {DATA_W{1'b0}};
        end else begin
            state_q   <= state_d;
            accDone_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (take && isEeprom) begin
                        // Hold the host off; the memory side may take many cycles.
                        accBusy_q <= 1'b1;
                        eeReq_q   <= 1'b1;
                        eeWrite_q <= accWrite;
                        eeAddr_q  <= xlateAddr;
                        eeWdata_q <= accWdata;
                    end else if (take) begin
                        accDone_q <= 1'b1;
                        if (!accWrite) begin
                            if (isStatic && bankHit) begin
                                rdData_q <= bank_read(bankSelect_q);
                            end else if (isStatic) begin
                                rdData_q <= staticMem[ofs];
                            end else begin
                                rdData_q <= configMem[ofs];
                            end
                        end
                    end
                end
                ST_MEM: begin
                    if (eeAck) begin
                        accBusy_q <= 1'b0;
                        accDone_q <= 1'b1;
                        eeReq_q   <= 1'b0;
                        if (!eeWrite_q) begin
                            rdData_q <= eeRdata;
                        end
                    end
                end
                default: begin
                    accBusy_q <= 1'b0;
                    eeReq_q   <= 1'b0;
                end
            endcase
        end
    end

endmodule // bsrm_regmap

`default_nettype wire

// ===== include/bsrm_map.vh
// Constants for the banked serial register map: offsets, fields and reset values.
`ifndef BSRM_MAP_VH
`define BSRM_MAP_VH

// ****************************************************************
// Serial address space
// ****************************************************************
`define BSRM_ADDR_W          7
`define BSRM_BANK_BYTES      64
`define BSRM_OFS_W           6
`define BSRM_DYN_LAST        7'h3F
`define BSRM_STATIC_FIRST    7'h40
`define BSRM_STATIC_LAST     7'h7F

// ****************************************************************
// Bank selection register
// ****************************************************************
`define BSRM_BANK_SELECT_ADDR  7'h40
`define BSRM_BANK_SELECT_RST   8'h00
`define BSRM_BANK_W            5
`define BSRM_BANK_LSB          0
`define BSRM_BANK_MSB          4
`define BSRM_BANK_CONFIG       5'h00
`define BSRM_BANK_MAX          5'h1F

// ****************************************************************
// External memory space
// ****************************************************************
`define BSRM_EE_ADDR_W       11

// ****************************************************************
// Bank 0 configuration layout
// ****************************************************************
`define BSRM_MASTER_GAIN_RANGE_AND_FINE  6'h00
`define BSRM_MASTER_GAIN_EXTRA           6'h01
`define BSRM_MASTER_SINE_OFFSET          6'h02
`define BSRM_MASTER_COSINE_OFFSET        6'h03
`define BSRM_COARSE_MSB      7
`define BSRM_COARSE_LSB      6
`define BSRM_FINE_MSB        5
`define BSRM_FINE_LSB        0
`define BSRM_FIELD7_MSB      6
`define BSRM_CONFIG_RST      8'h00
`define BSRM_STATIC_RST      8'h00

`endif

// ===== rtl/bsrm_bank_xlate.v
// Serial address translation into config, static or external memory targets.
`timescale 1ns/1ns
`default_nettype none
`include "bsrm_map.vh"

module bsrm_bank_xlate (
    input  wire [`BSRM_ADDR_W-1:0]    serAddr,
    input  wire [`BSRM_BANK_W-1:0]    bank,
    output reg                        isStatic,
    output reg                        isConfig,
    output reg                        isEeprom,
    output reg  [`BSRM_EE_ADDR_W-1:0] eeAddr
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    always @* begin
        // The upper half never depends on the bank value.
        isStatic = (serAddr >= `BSRM_STATIC_FIRST);
        isConfig = !isStatic && (bank == `BSRM_BANK_CONFIG);
        isEeprom = !isStatic && (bank != `BSRM_BANK_CONFIG);
        eeAddr   = {bank, serAddr[`BSRM_OFS_W-1:0]};
    end

endmodule // bsrm_bank_xlate

`default_nettype wire

// ===== tb/bsrm_regmap_monitor.sv
// Concurrent checks on the ports of the banked serial register map.
`timescale 1ns/1ns
`default_nettype none
module bsrm_regmap_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        accValid,
    input wire logic        accWrite,
    input wire logic [6:0]  accAddr,
    input wire logic [7:0]  accWdata,
    input wire logic        accBusy_q,
    input wire logic        accDone_q,
    input wire logic [7:0]  rdData_q,
    input wire logic        eeReq_q,
    input wire logic        eeWrite_q,
    input wire logic [10:0] eeAddr_q,
    input wire logic        eeAck,
    input wire logic [7:0]  eeRdata,
    input wire logic [4:0]  bankSelect_q,
    input wire logic [1:0]  masterCoarseGain_q,
    input wire logic [5:0]  masterFineGain_q
);
    wire logic take = accValid && !accBusy_q;
    wire logic toWin = take && !accAddr[6];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // A memory read closes one cycle after the acknowledge, carrying its byte.
    sequence eeFinish;
        ##1 accDone_q && !eeReq_q && rdData_q == $past(eeRdata);
    endsequence
    reset_clear_a: assert property ($fell(rst) |-> bankSelect_q == 5'h00 && !eeReq_q)
        else $error("bank or request not cleared after reset");
    bank_write_a: assert property (take && accWrite && accAddr == 7'h40 |=>
        bankSelect_q == $past(accWdata[4:0])) else $error("bank field not taken");
    static_fast_a: assert property (take && accAddr[6] |=> accDone_q && !eeReq_q)
        else $error("fixed section access not local");
    config_local_a: assert property (toWin && bankSelect_q == 5'h00 |=> accDone_q && !eeReq_q)
        else $error("bank 0 access went outside");
    ee_addr_a: assert property (toWin && bankSelect_q != 5'h00 |=> eeReq_q && accBusy_q &&
        eeAddr_q == {$past(bankSelect_q), $past(accAddr[5:0])}) else $error("bad memory address");
    ee_hold_a: assert property (eeReq_q && !eeAck |=> eeReq_q && $stable(eeAddr_q))
        else $error("memory request dropped early");
    ee_read_a: assert property (eeReq_q && eeAck && !eeWrite_q |-> eeFinish)
        else $error("memory read not returned");
    gain_write_a: assert property (toWin && accWrite && accAddr == 7'h00 && bankSelect_q == 5'h00
        |=> ##1 {masterCoarseGain_q, masterFineGain_q} == $past(accWdata, 2))
        else $error("gain not stored");
endmodule // bsrm_regmap_monitor
`default_nettype wire

// ===== tb/bsrm_ee_model.sv
// Behavioural external memory answering the request handshake.
`timescale 1ns/1ns
`default_nettype none
module bsrm_ee_model (
    input  wire logic        clk,
    input  wire logic        eeReq,
    input  wire logic        eeWrite,
    input  wire logic [10:0] eeAddr,
    input  wire logic [7:0]  eeWdata,
    input  wire logic [3:0]  dly,
    output var  logic        eeAck,
    output var  logic [7:0]  eeRdata
);
    logic [7:0] mem [0:2047];
    logic [3:0] cnt = 4'h0;
    initial eeAck = 1'b0;
    initial eeRdata = 8'h00;
    always @(posedge clk) begin
        eeAck <= 1'b0;
        // Data outside an acknowledge toggles so a stale byte is never mistaken for valid.
        eeRdata <= ~eeRdata;
        if (!eeReq || eeAck) begin
            cnt <= 4'h0;
        end else if (cnt < dly) begin
            cnt <= cnt + 4'h1;
        end else begin
            eeAck <= 1'b1;
            eeRdata <= mem[eeAddr];
            if (eeWrite) mem[eeAddr] <= eeWdata;
        end
    end
endmodule // bsrm_ee_model
`default_nettype wire

// ===== tb/bsrm_regmap_bench.sv
// Self-checking bench for the banked serial register map.
`timescale 1ns/1ns
`default_nettype none
module bsrm_regmap_bench;
    logic clk = 1'b0, rst = 1'b1, accValid = 1'b0, accWrite = 1'b0;
    logic [6:0] accAddr = 7'h00;
    logic [7:0] accWdata = 8'h00, rd;
    logic [3:0] dly = 4'h0;
    logic [4:0] bk [4] = '{5'h01, 5'h04, 5'h05, 5'h1F};
    wire logic accBusy_q, accDone_q, eeReq_q, eeWrite_q, eeAck;
    wire logic [7:0] rdData_q, eeWdata_q, eeRdata;
    wire logic [10:0] eeAddr_q;
    wire logic [4:0] bankSelect_q;
    wire logic [1:0] gc;
    wire logic [5:0] gf;
    wire logic [6:0] gx, vs, vc;
    int miscompares = 0, nCompared = 0;
    always #4 clk = ~clk;
    bsrm_regmap DUT (.clk(clk), .rst(rst), .accValid(accValid), .accWrite(accWrite),
        .accAddr(accAddr), .accWdata(accWdata), .accBusy_q(accBusy_q), .accDone_q(accDone_q),
        .rdData_q(rdData_q), .eeReq_q(eeReq_q), .eeWrite_q(eeWrite_q), .eeAddr_q(eeAddr_q),
        .eeWdata_q(eeWdata_q), .eeAck(eeAck), .eeRdata(eeRdata), .bankSelect_q(bankSelect_q),
        .masterCoarseGain_q(gc), .masterFineGain_q(gf), .masterGainExtra_q(gx),
        .masterSineOffset_q(vs), .masterCosineOffset_q(vc));
    bsrm_ee_model MEM (.clk(clk), .eeReq(eeReq_q), .eeWrite(eeWrite_q), .eeAddr(eeAddr_q),
        .eeWdata(eeWdata_q), .dly(dly), .eeAck(eeAck), .eeRdata(eeRdata));
    task report_and_stop;
        $display("compared %0d mismatched %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        nCompared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ****************************************************************
    // One access: request for one cycle, then wait for completion.
    // ****************************************************************
    task acc(input logic w, input logic [6:0] a, input logic [7:0] d);
        int i;
        accValid = 1'b1;
        accWrite = w;
        accAddr = a;
        accWdata = d;
        @(posedge clk);
        #1 accValid = 1'b0;
        for (i = 0; i < 40 && accDone_q !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("done", 11'h001, {10'h000, accDone_q});
        rd = rdData_q;
        // Let one edge pass so the next request never rewrites accValid in this time step.
        @(posedge clk);
        #1;
    endtask
    initial begin
        #40000;
        miscompares++;
        report_and_stop;
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        acc(1'b0, 7'h40, 8'h00);
        chk("bank read", 11'h000, {3'h0, rd});
        chk("bank out", 11'h000, {6'h00, bankSelect_q});
        $display("test reset done");
        acc(1'b1, 7'h00, 8'hC5);
        acc(1'b1, 7'h01, 8'h7A);
        acc(1'b1, 7'h02, 8'h15);
        acc(1'b1, 7'h03, 8'h2B);
        chk("gain", 11'h0C5, {3'h0, gc, gf});
        chk("extra", 11'h07A, {4'h0, gx});
        chk("sine", 11'h015, {4'h0, vs});
        chk("cosine", 11'h02B, {4'h0, vc});
        acc(1'b0, 7'h01, 8'h00);
        chk("config read", 11'h07A, {3'h0, rd});
        $display("test config done");
        for (int i = 0; i < 4; i++) begin
            dly = 4'(i * 5);
            acc(1'b1, 7'h40, {3'h7, bk[i]});
            acc(1'b0, 7'h40, 8'h00);
            chk("bank read", {6'h00, bk[i]}, {3'h0, rd});
            acc(1'b1, 7'h3F, {3'h2, bk[i]});
            chk("memory cell", {6'h02, bk[i]}, {3'h0, MEM.mem[{bk[i], 6'h3F}]});
            acc(1'b1, 7'h41, {3'h5, bk[i]});
            acc(1'b0, 7'h41, 8'h00);
            chk("static", {6'h05, bk[i]}, {3'h0, rd});
            acc(1'b0, 7'h3F, 8'h00);
            chk("window read", {6'h02, bk[i]}, {3'h0, rd});
        end
        $display("test banks done");
        acc(1'b1, 7'h40, 8'h00);
        acc(1'b0, 7'h00, 8'h00);
        chk("config kept", 11'h0C5, {3'h0, rd});
        $display("test return done");
        report_and_stop;
    end
endmodule // bsrm_regmap_bench
bind bsrm_regmap bsrm_regmap_monitor MON (.clk(clk), .rst(rst), .accValid(accValid),
    .accWrite(accWrite), .accAddr(accAddr), .accWdata(accWdata), .accBusy_q(accBusy_q),
    .accDone_q(accDone_q), .rdData_q(rdData_q), .eeReq_q(eeReq_q), .eeWrite_q(eeWrite_q),
    .eeAddr_q(eeAddr_q), .eeAck(eeAck), .eeRdata(eeRdata), .bankSelect_q(bankSelect_q),
    .masterCoarseGain_q(masterCoarseGain_q), .masterFineGain_q(masterFineGain_q));
`default_nettype wire
